// >>> verilog/hv_input_irq_and_adc_port_io.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: divider select 1 low ratio, 0 high
// R2: polarity 1 rising edge, 0 falling
// R3: enable 1 allows interrupt, 0 masks
// R4: software enables interrupt for stop wakeup
// R5: flag set on edge matching polarity
// R6: request when any flag and enable set
// R7: write one clears flag, zero keeps
// R8: divider, polarity, enable registers read/write anytime
// R9: port pins serve as general-purpose I/O
// R10: output pins drive data register bits
// R11: output-direction data read returns register
// R12: input-direction data read returns synchronized pin
// R13: input register read-only, pin or one
// R14: direction 1 output, 0 input
// R15: digital input only with converter enable
// R16: divider applies only to connected selected pin
// R17: pin inputs synchronized before use
// R18: disabled input data read returns one
// R19: data upper bits zero, reset zero
module hv_input_irq_and_adc_port_io
    import hvport_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [HV_PINS-1:0] high_voltage_input_pin,
    input wire logic [AD_PINS-1:0] adc_port_pin_in,
    output logic [AD_PINS-1:0] adc_port_pin_out,
    output logic [AD_PINS-1:0] adc_port_pin_oe,
    input wire logic [AD_PINS-1:0] converter_digital_input_enable,
    output logic [HV_PINS-1:0] hv_low_ratio_select,
    output logic hv_port_irq,
    output logic irq
);
    typedef struct packed {
        logic [2:0][HV_PINS-1:0] hv_sync;
        logic [2:0][AD_PINS-1:0] ad_sync;
        logic [HV_PINS-1:0] hv_level;
        logic [AD_PINS-1:0] ad_level;
        logic [HV_PINS-1:0] div_sel;
        logic [HV_PINS-1:0] pol_sel;
        logic [HV_PINS-1:0] irq_en;
        logic [HV_PINS-1:0] irq_flag;
        logic [AD_PINS-1:0] port_data;
        logic [AD_PINS-1:0] port_dir;
        logic [2:0] analog_ctrl;
        logic [HV_PINS-1:0] irq_mask;
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        logic [AD_PINS-1:0] pin_out;
        logic [AD_PINS-1:0] pin_oe;
        logic [HV_PINS-1:0] low_ratio;
        logic port_irq;
        logic irq;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [AD_PINS-1:0] din_en;
    logic [AD_PINS-1:0] in_view;
    logic [AD_PINS-1:0] data_view;
    logic [HV_PINS-1:0] edge_hit;
    logic [HV_PINS-1:0] flag_clr;
    logic rd_take;
    logic wr_take;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    always_comb begin
        st_nxt = st_r;
        // R17: three flops, change counts when last two agree
        st_nxt.hv_sync = {st_r.hv_sync[1:0], high_voltage_input_pin};
        st_nxt.ad_sync = {st_r.ad_sync[1:0], adc_port_pin_in};
        for (int i = 0; i < HV_PINS; i++) begin
            if (st_r.hv_sync[1][i] == st_r.hv_sync[2][i]) begin
                st_nxt.hv_level[i] = st_r.hv_sync[2][i];
            end
        end
        for (int i = 0; i < AD_PINS; i++) begin
            if (st_r.ad_sync[1][i] == st_r.ad_sync[2][i]) begin
                st_nxt.ad_level[i] = st_r.ad_sync[2][i];
            end
        end
        // R5: R2: edge in direction chosen by polarity
        for (int i = 0; i < HV_PINS; i++) begin
            edge_hit[i] = (st_nxt.hv_level[i] != st_r.hv_level[i]) && (st_nxt.hv_level[i] == st_r.pol_sel[i]);
        end
        // R15: R13: R18: input path only with converter enable
        din_en = converter_digital_input_enable;
        in_view = (st_r.ad_level & din_en) | ~din_en;
        // R11: R12: data read source follows direction
        data_view = (st_r.port_data & st_r.port_dir) | (in_view & ~st_r.port_dir);

        rd_take = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
        wr_take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
        wbyte = hwdata[7:0];
        st_nxt.wr_pend = wr_take;
        if (wr_take) begin
            st_nxt.wr_addr = haddr;
        end
        flag_clr = '0;
        if (st_r.wr_pend) begin
            // R8: control registers writable anytime
            unique case (st_r.wr_addr)
                OFF_ADC_PORT_DATA: st_nxt.port_data = wbyte[AD_PINS-1:0];
                OFF_HV_DIVIDER_RATIO_SELECT: st_nxt.div_sel = wbyte[HV_PINS-1:0];
                OFF_HV_EDGE_POLARITY_SELECT: st_nxt.pol_sel = wbyte[HV_PINS-1:0];
                OFF_HV_PIN_IRQ_ENABLE: st_nxt.irq_en = wbyte[HV_PINS-1:0];
                // R7: write one clears
                OFF_HV_PIN_IRQ_FLAGS: flag_clr = wbyte[HV_PINS-1:0];
                OFF_ADC_PORT_DIRECTION: st_nxt.port_dir = wbyte[AD_PINS-1:0];
                OFF_HV_ANALOG_CTRL: st_nxt.analog_ctrl = wbyte[2:0];
                OFF_IRQ_MASK: st_nxt.irq_mask = wbyte[HV_PINS-1:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        st_nxt.irq_flag = (st_r.irq_flag & ~flag_clr) | edge_hit;

        rbyte = 8'h00;
        unique case (haddr)
            // R19: upper data bits read zero
            OFF_ADC_PORT_DATA: rbyte = {2'b00, data_view};
            OFF_HV_DIVIDER_RATIO_SELECT: rbyte = {4'h0, st_r.div_sel};
            OFF_HV_EDGE_POLARITY_SELECT: rbyte = {4'h0, st_r.pol_sel};
            OFF_HV_PIN_IRQ_ENABLE: rbyte = {4'h0, st_r.irq_en};
            OFF_HV_PIN_IRQ_FLAGS: rbyte = {4'h0, st_r.irq_flag};
            OFF_ADC_PORT_PIN_INPUT: rbyte = {2'b00, in_view};
            OFF_ADC_PORT_DIRECTION: rbyte = {2'b00, st_r.port_dir};
            OFF_HV_ANALOG_CTRL: rbyte = {5'h00, st_r.analog_ctrl};
            OFF_IRQ_MASK: rbyte = {4'h0, st_r.irq_mask};
            default: rbyte = 8'h00;
        endcase
        if (rd_take) begin
            st_nxt.rdata = {24'h000000, rbyte};
        end

        // R9: R10: R14: direction selects output drive
        st_nxt.pin_oe = st_r.port_dir;
        st_nxt.pin_out = st_r.port_data;
        // R1: R16: low ratio only on the connected selected pin
        for (int i = 0; i < HV_PINS; i++) begin
            st_nxt.low_ratio[i] = st_r.analog_ctrl[ANALOG_EN_BIT] && st_r.analog_ctrl[1:0] == 2'(i)
                && st_r.div_sel[i];
        end
        // R3: R6: request from flag and enable
        st_nxt.port_irq = |(st_nxt.irq_flag & st_r.irq_en);
        st_nxt.irq = |(st_nxt.irq_flag & st_r.irq_en & st_r.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hrdata = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign adc_port_pin_out = st_r.pin_out;
    assign adc_port_pin_oe = st_r.pin_oe;
    assign hv_low_ratio_select = st_r.low_ratio;
    assign hv_port_irq = st_r.port_irq;
    assign irq = st_r.irq;

    sequence s_clear_write(int b);
        st_r.wr_pend && st_r.wr_addr == OFF_HV_PIN_IRQ_FLAGS && hwdata[b] && !edge_hit[b];
    endsequence

    // address phase of a write, then its data phase
    sequence s_reg_write(logic [11:0] a);
        wr_take && haddr == a ##1 1'b1;
    endsequence

    sequence s_hv_rise(int b);
        !st_r.hv_level[b] && st_nxt.hv_level[b];
    endsequence

    sequence s_hv_fall(int b);
        st_r.hv_level[b] && !st_nxt.hv_level[b];
    endsequence

    // R7: write one clears
    a_flag_clear_w1c: assert property (@(posedge hclk) disable iff (!hresetn) // R7
        s_clear_write(0) |=> !st_r.irq_flag[0]) else $error("flag not cleared");

    // R5: edge sets flag
    a_flag_rise_set: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        edge_hit[1] |=> st_r.irq_flag[1]) else $error("flag not set on edge");

    // R2: edge direction checked
    a_flag_no_wrong_edge: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        $rose(st_r.irq_flag[2]) |-> $past(st_r.pol_sel[2]) == $past(st_nxt.hv_level[2], 1)) else
        $error("flag on wrong edge");

    // R6: request level
    a_port_irq_level: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        ##1 hv_port_irq == |($past(st_nxt.irq_flag) & $past(st_r.irq_en))) else $error("request wrong");

    // R3: disabled request
    a_port_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        (st_r.irq_en == 4'h0) [*2] |-> !hv_port_irq) else $error("disabled request");

    // R10: pin drive
    a_output_drive: assert property (@(posedge hclk) disable iff (!hresetn) // R10
        ##1 adc_port_pin_oe == $past(st_r.port_dir) && adc_port_pin_out == $past(st_r.port_data)) else
        $error("pin drive wrong");

    // R13: disabled input reads one
    a_input_read_one: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        rd_take && haddr == OFF_ADC_PORT_PIN_INPUT && din_en == 6'h00 |=> hrdata == 32'h0000003F) else
        $error("disabled input not one");

    // R19: upper bits zero
    a_data_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R19
        rd_take && haddr == OFF_ADC_PORT_DATA |=> hrdata[31:6] == 26'h0) else $error("upper data bits set");

    // R11: output data read
    a_data_read_out: assert property (@(posedge hclk) disable iff (!hresetn) // R11
        rd_take && haddr == OFF_ADC_PORT_DATA && st_r.port_dir == 6'h3F && !st_r.wr_pend |=>
        hrdata[5:0] == $past(st_r.port_data)) else $error("output data read wrong");

    // R16: ratio needs connection
    a_ratio_gated: assert property (@(posedge hclk) disable iff (!hresetn) // R16
        !st_r.analog_ctrl[ANALOG_EN_BIT] [*2] |-> hv_low_ratio_select == 4'h0) else $error("ratio unconnected");

    // R17: first stage samples pin
    a_hv_sync_shift: assert property (@(posedge hclk) disable iff (!hresetn) // R17
        st_r.hv_sync[0] == $past(high_voltage_input_pin))
        else $error("hv sync stage wrong");

    // R17: first stage samples pin
    a_ad_sync_shift: assert property (@(posedge hclk) disable iff (!hresetn) // R17
        st_r.ad_sync[0] == $past(adc_port_pin_in))
        else $error("port sync stage wrong");

    // R17: level moves only on agreement
    a_hv_level_agree: assert property (@(posedge hclk) disable iff (!hresetn) // R17
        ((st_r.hv_level ^ $past(st_r.hv_level)) & ($past(st_r.hv_sync[1]) ^ $past(st_r.hv_sync[2]))) == 4'h0)
        else $error("hv level moved early");

    // R17: agreed level is taken
    a_hv_level_follow: assert property (@(posedge hclk) disable iff (!hresetn) // R17
        ((st_r.hv_level ^ $past(st_r.hv_sync[2])) & ~($past(st_r.hv_sync[1]) ^ $past(st_r.hv_sync[2]))) == 4'h0)
        else $error("hv level not taken");

    // R17: port level moves only on agreement
    a_ad_level_agree: assert property (@(posedge hclk) disable iff (!hresetn) // R17
        ((st_r.ad_level ^ $past(st_r.ad_level)) & ($past(st_r.ad_sync[1]) ^ $past(st_r.ad_sync[2]))) == 6'h00)
        else $error("port level moved early");

    // R2: rising edge on pin three
    a_edge_rise_pol: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        s_hv_rise(3) |-> edge_hit[3] == st_r.pol_sel[3])
        else $error("rising edge misjudged");

    // R2: falling edge on pin three
    a_edge_fall_pol: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        s_hv_fall(3) |-> edge_hit[3] == !st_r.pol_sel[3])
        else $error("falling edge misjudged");

    // R5: no flag without edge
    a_flag_needs_edge: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        (st_r.irq_flag & ~$past(st_r.irq_flag) & ~$past(edge_hit)) == 4'h0)
        else $error("flag set without edge");

    // R7: flag sticky until cleared
    a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R7
        ($past(st_r.irq_flag) & ~st_r.irq_flag & ~$past(flag_clr)) == 4'h0)
        else $error("flag lost without clear");

    // R7: set beats clear
    a_flag_set_wins: assert property (@(posedge hclk) disable iff (!hresetn) // R7
        |(edge_hit & flag_clr) |=> (st_r.irq_flag & $past(edge_hit & flag_clr)) == $past(edge_hit & flag_clr))
        else $error("clear beat set");

    // R3: masked interrupt level
    a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        irq == |($past(st_nxt.irq_flag) & $past(st_r.irq_en) & $past(st_r.irq_mask)))
        else $error("interrupt level wrong");

    // R6: interrupt implies request
    a_irq_has_request: assert property (@(posedge hclk) disable iff (!hresetn) // R6
        irq |-> hv_port_irq)
        else $error("interrupt without request");

    // R3: request needs an enable
    a_request_needs_en: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        hv_port_irq |-> $past(st_r.irq_en) != 4'h0)
        else $error("request with no enable");

    // R16: at most one pin divided low
    a_ratio_single: assert property (@(posedge hclk) disable iff (!hresetn) // R16
        $onehot0(hv_low_ratio_select))
        else $error("several pins selected");

    // R1: selected pin follows its bit
    a_ratio_follow: assert property (@(posedge hclk) disable iff (!hresetn) // R1
        hv_low_ratio_select == (($past(st_r.analog_ctrl[ANALOG_EN_BIT] && st_r.div_sel[st_r.analog_ctrl[1:0]]))
        ? (4'h1 << $past(st_r.analog_ctrl[1:0])) : 4'h0))
        else $error("ratio select wrong");

    // R1: zero bits keep high ratio
    a_ratio_high: assert property (@(posedge hclk) disable iff (!hresetn) // R1
        (st_r.div_sel == 4'h0) [*2] |-> hv_low_ratio_select == 4'h0)
        else $error("low ratio without select");

    // R14: inputs not driven
    a_dir_input_float: assert property (@(posedge hclk) disable iff (!hresetn) // R14
        (st_r.port_dir == 6'h00) [*2] |-> adc_port_pin_oe == 6'h00)
        else $error("input pin driven");

    // R8: no wait states
    a_bus_ready: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        hreadyout)
        else $error("bus not ready");

    // R8: response always okay
    a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        !hresp)
        else $error("error response");

    // R13: input register view
    a_input_read_pin: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        rd_take && haddr == OFF_ADC_PORT_PIN_INPUT |=> hrdata == {26'h0, $past(st_r.ad_level) | ~$past(din_en)})
        else $error("input register wrong");

    // R12: input data read sees pin
    a_data_read_in: assert property (@(posedge hclk) disable iff (!hresetn) // R12
        rd_take && haddr == OFF_ADC_PORT_DATA && st_r.port_dir == 6'h00 && din_en == 6'h3F |=>
        hrdata[5:0] == $past(st_r.ad_level)) else $error("input data read wrong");

    // R18: disabled input data reads one
    a_data_read_off: assert property (@(posedge hclk) disable iff (!hresetn) // R18
        rd_take && haddr == OFF_ADC_PORT_DATA && st_r.port_dir == 6'h00 && din_en == 6'h00 |=>
        hrdata == 32'h0000003F) else $error("disabled data read wrong");

    // R8: unmapped space reads zero
    a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        rd_take && haddr[11:8] == 4'h3 && haddr[7:5] != 3'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");

    // R8: read data holds
    a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        !rd_take |=> $stable(hrdata))
        else $error("read data moved");

    // R8: divider write lands
    a_div_write: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        s_reg_write(OFF_HV_DIVIDER_RATIO_SELECT) |=> st_r.div_sel == $past(hwdata[3:0]))
        else $error("divider write lost");

    // R8: polarity write lands
    a_pol_write: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        s_reg_write(OFF_HV_EDGE_POLARITY_SELECT) |=> st_r.pol_sel == $past(hwdata[3:0]))
        else $error("polarity write lost");

    // R8: enable write lands
    a_en_write: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        s_reg_write(OFF_HV_PIN_IRQ_ENABLE) |=> st_r.irq_en == $past(hwdata[3:0]))
        else $error("enable write lost");

    // R14: direction write lands
    a_dir_write: assert property (@(posedge hclk) disable iff (!hresetn) // R14
        s_reg_write(OFF_ADC_PORT_DIRECTION) |=> st_r.port_dir == $past(hwdata[5:0]))
        else $error("direction write lost");

    // R19: data write keeps low bits
    a_data_write: assert property (@(posedge hclk) disable iff (!hresetn) // R19
        s_reg_write(OFF_ADC_PORT_DATA) |=> st_r.port_data == $past(hwdata[5:0]))
        else $error("data write lost");
endmodule : hv_input_irq_and_adc_port_io

// >>> verilog/hvport_pkg.sv
package hvport_pkg;
    // register byte offsets (one aligned word each)
    // printed register index; byte address is four times the index
    localparam logic [11:0] IDX_ADC_PORT_DATA = 12'h271;
    localparam logic [11:0] OFF_ADC_PORT_DATA = {IDX_ADC_PORT_DATA[9:0], 2'b00};
    localparam logic [11:0] OFF_HV_DIVIDER_RATIO_SELECT = 12'h300;
    localparam logic [11:0] OFF_HV_EDGE_POLARITY_SELECT = 12'h304;
    localparam logic [11:0] OFF_HV_PIN_IRQ_ENABLE = 12'h308;
    localparam logic [11:0] OFF_HV_PIN_IRQ_FLAGS = 12'h30C;
    localparam logic [11:0] OFF_ADC_PORT_PIN_INPUT = 12'h310;
    localparam logic [11:0] OFF_ADC_PORT_DIRECTION = 12'h314;
    localparam logic [11:0] OFF_HV_ANALOG_CTRL = 12'h318;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h31C;
    localparam int HV_PINS = 4;
    localparam int AD_PINS = 6;
    localparam int ANALOG_EN_BIT = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : hvport_pkg

// >>> sim/hv_input_irq_and_adc_port_io_tb.sv
`timescale 1ns/10ps
module hv_input_irq_and_adc_port_io_tb;
    import hvport_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [3:0] hv_pin = 4'h0;
    logic [5:0] ad_in = 6'h00;
    logic [5:0] ad_out;
    logic [5:0] ad_oe;
    logic [5:0] dien = 6'h00;
    logic [3:0] low_ratio;
    logic hv_port_irq;
    logic irq;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [31:0] q;

    hv_input_irq_and_adc_port_io uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .high_voltage_input_pin(hv_pin),
        .adc_port_pin_in(ad_in), .adc_port_pin_out(ad_out), .adc_port_pin_oe(ad_oe),
        .converter_digital_input_enable(dien), .hv_low_ratio_select(low_ratio),
        .hv_port_irq(hv_port_irq), .irq(irq));

    always #5 hclk = ~hclk;

    task automatic summarize;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // one single transfer; entered just after a rising edge
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic wait_pins;
        repeat (8) @(posedge hclk);
    endtask : wait_pins

    logic [11:0] ra [3] = '{OFF_HV_DIVIDER_RATIO_SELECT, OFF_HV_EDGE_POLARITY_SELECT, OFF_HV_PIN_IRQ_ENABLE};

    task automatic test_resets;
        rd(OFF_ADC_PORT_DATA, 32'h3F);
        rd(OFF_ADC_PORT_PIN_INPUT, 32'h3F);
        rd(OFF_HV_PIN_IRQ_FLAGS, 32'h0);
        rd(12'h3F0, 32'h0);
        foreach (ra[i]) begin
            xfer(ra[i], 1'b1, 32'hFF);
            rd(ra[i], 32'h0F);
            xfer(ra[i], 1'b1, 32'h0);
        end
    endtask : test_resets

    task automatic test_port;
        xfer(OFF_ADC_PORT_DIRECTION, 1'b1, 32'h3F);
        xfer(OFF_ADC_PORT_DATA, 1'b1, 32'hFF);
        rd(OFF_ADC_PORT_DATA, 32'h3F);
        chk({ad_oe, ad_out}, 12'hFFF);
        dien <= 6'h3F;
        ad_in <= 6'h15;
        wait_pins();
        rd(OFF_ADC_PORT_PIN_INPUT, 32'h15);
        rd(OFF_ADC_PORT_DATA, 32'h3F);
        xfer(OFF_ADC_PORT_DIRECTION, 1'b1, 32'h0);
        rd(OFF_ADC_PORT_DATA, 32'h15);
        chk(ad_oe, 6'h00);
        dien <= 6'h0C;
        rd(OFF_ADC_PORT_DATA, 32'h37);
    endtask : test_port

    task automatic test_irq;
        xfer(OFF_HV_EDGE_POLARITY_SELECT, 1'b1, 32'h5);
        xfer(OFF_HV_PIN_IRQ_ENABLE, 1'b1, 32'hF);
        xfer(OFF_IRQ_MASK, 1'b1, 32'hF);
        hv_pin <= 4'hF;
        wait_pins();
        rd(OFF_HV_PIN_IRQ_FLAGS, 32'h5);
        chk({hv_port_irq, irq}, 2'b11);
        xfer(OFF_HV_PIN_IRQ_FLAGS, 1'b1, 32'h1);
        rd(OFF_HV_PIN_IRQ_FLAGS, 32'h4);
        hv_pin <= 4'h0;
        wait_pins();
        rd(OFF_HV_PIN_IRQ_FLAGS, 32'hE);
        xfer(OFF_IRQ_MASK, 1'b1, 32'h0);
        repeat (2) @(posedge hclk);
        chk({hv_port_irq, irq}, 2'b10);
        xfer(OFF_HV_PIN_IRQ_ENABLE, 1'b1, 32'h0);
        repeat (2) @(posedge hclk);
        chk(hv_port_irq, 1'b0);
        xfer(OFF_HV_PIN_IRQ_FLAGS, 1'b1, 32'hF);
        rd(OFF_HV_PIN_IRQ_FLAGS, 32'h0);
    endtask : test_irq

    task automatic test_divider;
        xfer(OFF_HV_DIVIDER_RATIO_SELECT, 1'b1, 32'h2);
        xfer(OFF_HV_ANALOG_CTRL, 1'b1, 32'h5);
        repeat (2) @(posedge hclk);
        chk(low_ratio, 4'h2);
        xfer(OFF_HV_ANALOG_CTRL, 1'b1, 32'h4);
        repeat (2) @(posedge hclk);
        chk(low_ratio, 4'h0);
        xfer(OFF_HV_ANALOG_CTRL, 1'b1, 32'h1);
        repeat (2) @(posedge hclk);
        chk(low_ratio, 4'h0);
    endtask : test_divider

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_resets();
        test_port();
        test_irq();
        test_divider();
        summarize();
    end
endmodule : hv_input_irq_and_adc_port_io_tb
